// ==== lrs_pkg.sv ====
// Package of constants and types for the lcd row scan shifter
// Behaviour
// - 80-stage chain shifts on scan clock fall
// - Split low: one 80-stage chain end to end
// - Split high: two 40-stage chains, mid input
// - All four split and direction combinations
// - Last stage bit drives output-side end pin
// - Bit and alternation pick one of four levels
// - Blank low forces top drive level everywhere
package lrs_pkg;

  // ----------------------------------------------------------------
  // Chain geometry
  // ----------------------------------------------------------------
  localparam int STAGES = 80;
  localparam int HALF   = 40;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_CHAIN0 = 8'h04;
  localparam logic [7:0] ADDR_CHAIN1 = 8'h08;
  localparam logic [7:0] ADDR_CHAIN2 = 8'h0c;
  localparam logic [7:0] ADDR_SHIFTS = 8'h10;

  // Control field positions and reset value
  localparam int CTRL_SPLIT_BIT = 0;
  localparam int CTRL_DIR_BIT   = 1;
  localparam int CTRL_BLANK_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Synchroniser depth and reset values
  localparam int SYNC_DEPTH = 3;
  localparam logic [31:0] SHIFTS_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Drive level codes, one per row output
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_TOP_SELECTED     = 2'b00,
    LVL_UPPER_UNSELECTED = 2'b01,
    LVL_LOWER_UNSELECTED = 2'b10,
    LVL_BOTTOM_SELECTED  = 2'b11
  } lrs_level_t;

endpackage

// ==== lrs_sync.sv ====
// Three-stage input synchroniser with agreement qualifier
module lrs_sync
  import lrs_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Asynchronous inputs
  input  wire logic [WIDTH-1:0] async_in,
  // Qualified level
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // A bit only changes once stages two and three agree, filtering glitches
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      assign level_next[g] = (ff2_reg[g] == ff3_reg[g]) ? ff3_reg[g] : level_reg[g];
    end
  endgenerate

  // Shift chain; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ff1_reg   <= '0;
      ff2_reg   <= '0;
      ff3_reg   <= '0;
      level_reg <= '0;
    end
    else
    begin
      ff1_reg   <= async_in;
      ff2_reg   <= ff1_reg;
      ff3_reg   <= ff2_reg;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule // lrs_sync

// ==== lrs_top.sv ====
// Row scan shift register with drive level select and AHB-Lite registers
module lrs_top
  import lrs_pkg::*;
(
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // Scan link from the timing controller
  input  wire logic         scan_shift_clock,
  input  wire logic         mid_chain_data_in,
  input  wire logic         frame_alternation,
  // First end serial pin
  input  wire logic         first_end_serial_io_in,
  output logic              first_end_serial_io_out,
  output logic              first_end_serial_io_oe_n,
  // Last end serial pin
  input  wire logic         last_end_serial_io_in,
  output logic              last_end_serial_io_out,
  output logic              last_end_serial_io_oe_n,
  // Row drive level codes, two bits per row, row 1 in bits 1:0
  output logic [2*STAGES-1:0] row_drive
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_async;
  logic [4:0] pins_q;
  wire        clk_q   = pins_q[0];
  wire        first_q = pins_q[1];
  wire        last_q  = pins_q[2];
  wire        mid_q   = pins_q[3];
  wire        alt_q   = pins_q[4];

  assign pins_async = {frame_alternation, mid_chain_data_in, last_end_serial_io_in,
                       first_end_serial_io_in, scan_shift_clock};

  lrs_sync #(.WIDTH(5)) u_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .async_in  (pins_async),
    .level_out (pins_q)
  );

  // ----------------------------------------------------------------
  // Control register and bus state
  // ----------------------------------------------------------------
  logic [2:0]        ctrl_reg;
  logic [STAGES-1:0] chain_reg;
  logic [STAGES-1:0] chain_next;
  logic              clk_prev_reg;
  logic [31:0]       shifts_reg;
  logic              wr_pend_reg;
  logic [7:0]        wr_addr_reg;
  logic [31:0]       hrdata_reg;
  logic              first_out_reg;
  logic              last_out_reg;
  logic              first_oe_n_reg;
  logic              last_oe_n_reg;
  logic [2*STAGES-1:0] drive_reg;
  logic [2*STAGES-1:0] drive_next;

  wire split_mode = ctrl_reg[CTRL_SPLIT_BIT];
  wire shift_left = ctrl_reg[CTRL_DIR_BIT];
  wire display_blank_n = ctrl_reg[CTRL_BLANK_BIT];

  // Falling edge of the qualified scan clock
  wire shift_pulse = clk_prev_reg & ~clk_q;

  // ----------------------------------------------------------------
  // Chain next state
  // ----------------------------------------------------------------
  // Each stage takes its neighbour on the input side; the end stages and,
  // in split mode, the two stages beside the middle take the pins instead.
  genvar i;
  generate
    for (i = 0; i < STAGES; i++)
    begin : g_stage
      wire from_low;
      wire from_high;
      if (i == 0)
      begin : g_lo_end
        assign from_low = first_q;
      end
      else if (i == HALF)
      begin : g_lo_mid
        assign from_low = split_mode ? mid_q : chain_reg[i-1];
      end
      else
      begin : g_lo
        assign from_low = chain_reg[i-1];
      end
      if (i == STAGES-1)
      begin : g_hi_end
        assign from_high = last_q;
      end
      else if (i == HALF-1)
      begin : g_hi_mid
        assign from_high = split_mode ? mid_q : chain_reg[i+1];
      end
      else
      begin : g_hi
        assign from_high = chain_reg[i+1];
      end
      // Direction and split jointly choose the source
      assign chain_next[i] = shift_pulse ? (shift_left ? from_high : from_low)
                                         : chain_reg[i];

      // Drive level: blank forces top, else bit and alternation pick.
      // Taken from the next chain state so rows and end pins move on one edge.
      assign drive_next[2*i+1:2*i] =
        !display_blank_n ? LVL_TOP_SELECTED :
        chain_next[i] ? (alt_q ? LVL_TOP_SELECTED : LVL_BOTTOM_SELECTED)
                     : (alt_q ? LVL_LOWER_UNSELECTED : LVL_UPPER_UNSELECTED);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Cascade pins
  // ----------------------------------------------------------------
  // Output end pin carries the last stage of the chain; the input end is released.
  wire first_out_next = chain_next[0];
  wire last_out_next  = chain_next[STAGES-1];

  // Scan datapath registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chain_reg    <= '0;
      clk_prev_reg <= 1'b0;
      shifts_reg   <= SHIFTS_RESET;
    end
    else
    begin
      chain_reg    <= chain_next;
      clk_prev_reg <= clk_q;
      shifts_reg   <= shift_pulse ? shifts_reg + 32'h0000_0001 : shifts_reg;
    end
  end

  // Output stage registers, so every pin comes straight from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      first_out_reg  <= 1'b0;
      last_out_reg   <= 1'b0;
      first_oe_n_reg <= 1'b1;
      last_oe_n_reg  <= 1'b0;
      drive_reg      <= '0;
    end
    else
    begin
      first_out_reg  <= first_out_next;
      last_out_reg   <= last_out_next;
      first_oe_n_reg <= ~shift_left;
      last_oe_n_reg  <= shift_left;
      drive_reg      <= drive_next;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait state: address phase captured, write done in the data phase.
  wire        bus_valid = hsel & hready & htrans[1];
  wire        bus_write = bus_valid & hwrite;
  wire        bus_read  = bus_valid & ~hwrite;
  wire [7:0]  bus_addr  = haddr[7:0];
  wire        bus_hit   = (haddr[31:8] == 24'h00_0000);
  wire [31:0] rd_mux =
    !bus_hit                    ? 32'h0000_0000 :
    (bus_addr == ADDR_CTRL)     ? {29'h0000_0000, ctrl_reg} :
    (bus_addr == ADDR_CHAIN0)   ? chain_reg[31:0] :
    (bus_addr == ADDR_CHAIN1)   ? chain_reg[63:32] :
    (bus_addr == ADDR_CHAIN2)   ? {16'h0000, chain_reg[79:64]} :
    (bus_addr == ADDR_SHIFTS)   ? shifts_reg :
                                  32'h0000_0000;
  wire ctrl_wr = wr_pend_reg & (wr_addr_reg == ADDR_CTRL);

  // Bus phase tracking and read data capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= bus_write & bus_hit;
      wr_addr_reg <= bus_addr;
      hrdata_reg  <= bus_read ? rd_mux : hrdata_reg;
    end
  end

  // Control register; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (ctrl_wr)
    begin
      ctrl_reg <= hwdata[2:0];
    end
  end

  // Constant answers held in flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata                   = hrdata_reg;
  assign first_end_serial_io_out  = first_out_reg;
  assign first_end_serial_io_oe_n = first_oe_n_reg;
  assign last_end_serial_io_out   = last_out_reg;
  assign last_end_serial_io_oe_n  = last_oe_n_reg;
  assign row_drive                = drive_reg;

endmodule // lrs_top

// ==== lrs_assertions.sv ====
// Port-level assertions for the row scan shifter
module lrs_assertions
  import lrs_pkg::*;
(
  // Clock, reset and bus answer
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // Scan pins and rows
  input wire logic                scan_shift_clock,
  input wire logic                first_end_serial_io_out,
  input wire logic                first_end_serial_io_oe_n,
  input wire logic                last_end_serial_io_out,
  input wire logic                last_end_serial_io_oe_n,
  input wire logic [2*STAGES-1:0] row_drive
);
  // ----
  // Helpers
  // ----
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0]        low_age;
  logic [STAGES-1:0] lo;
  // Cycles since scan clock was low; pins may only move shortly after a fall
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) low_age <= 8'hff;
    else if (!scan_shift_clock) low_age <= 8'h00;
    else if (low_age != 8'hff) low_age <= low_age + 8'h01;
  // Low code bit per row; one alternation level serves every row
  always_comb
    for (int i = 0; i < STAGES; i++) lo[i] = row_drive[2*i];
  ready_high_a: assert property (hreadyout == 1'b1) else $error("bus stalled");
  okay_resp_a: assert property (hresp == 1'b0) else $error("bus error response");
  end_roles_a: assert property (first_end_serial_io_oe_n != last_end_serial_io_oe_n)
    else $error("both end pins in one role");
  first_move_a: assert property ($changed(first_end_serial_io_out) |-> low_age <= 8'h08)
    else $error("first end moved without scan fall");
  last_move_a: assert property ($changed(last_end_serial_io_out) |-> low_age <= 8'h08)
    else $error("last end moved without scan fall");
  first_code_a: assert property (row_drive[1:0] != LVL_TOP_SELECTED |->
    first_end_serial_io_out == (row_drive[1:0] == LVL_BOTTOM_SELECTED))
    else $error("row 1 level disagrees with stage 1");
  last_code_a: assert property (row_drive[159:158] != LVL_TOP_SELECTED |->
    last_end_serial_io_out == (row_drive[159:158] == LVL_BOTTOM_SELECTED))
    else $error("row 80 level disagrees with stage 80");
  alt_uniform_a: assert property (lo == '0 || lo == '1)
    else $error("rows disagree on alternation");
  cover property ($fell(scan_shift_clock));
  cover property ($rose(last_end_serial_io_out));
  cover property (!first_end_serial_io_oe_n && lo == '1);
endmodule // lrs_assertions

bind lrs_top lrs_assertions u_lrs_assertions (.hclk, .hresetn, .hreadyout, .hresp,
  .scan_shift_clock, .first_end_serial_io_out, .first_end_serial_io_oe_n,
  .last_end_serial_io_out, .last_end_serial_io_oe_n, .row_drive);

// ==== lrs_ctrl_model.sv ====
// Timing controller model: scan clock pulses and serial data
module lrs_ctrl_model (
  // Clock, reset and request
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic d_first,
  input wire logic d_last,
  input wire logic d_mid,
  // Pins toward the shifter
  output logic     scan_shift_clock,
  output logic     first_pin,
  output logic     last_pin,
  output logic     mid_pin,
  output logic     busy
);
  // ----
  // Pulse sequencer
  // ----
  logic [4:0] cnt;
  logic [2:0] held;
  // Six cycles setup, low and hold each, above the synchroniser minimum
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) cnt <= 5'h00;
    else if (go && cnt == 5'h00) cnt <= 5'h12;
    else if (cnt != 5'h00) cnt <= cnt - 5'h01;
  // Data captured once per pulse
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) held <= 3'h0;
    else if (go && cnt == 5'h00) held <= {d_first, d_last, d_mid};
  // Clock idles high; released lines flip so stale data never looks valid
  assign busy = cnt != 5'h00;
  assign scan_shift_clock = !(cnt >= 5'h07 && cnt <= 5'h0c);
  assign {first_pin, last_pin, mid_pin} = busy ? held : ~held;
endmodule // lrs_ctrl_model

// ==== lrs_tb_top.sv ====
// Self-checking bench for the row scan shifter
module lrs_tb_top
  import lrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Signals and instances
  // ----
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, alt = 1'b0;
  logic d_first = 1'b0, d_last = 1'b0, d_mid = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] ctrl = 3'h0;
  logic [STAGES-1:0] ref_q = '0;
  logic [31:0] hrdata;
  logic [2*STAGES-1:0] row_drive;
  logic hreadyout, hresp, scan, m_first, m_last, m_mid, busy, f_out, f_oe, l_out, l_oe;
  wire f_in = f_oe ? m_first : f_out;
  wire l_in = l_oe ? m_last : l_out;
  int miscompares = 0;
  int tests_run = 0;
  always #10 hclk = ~hclk;
  lrs_top u_lrs_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .scan_shift_clock(scan),
    .mid_chain_data_in(m_mid), .frame_alternation(alt), .first_end_serial_io_in(f_in),
    .first_end_serial_io_out(f_out), .first_end_serial_io_oe_n(f_oe),
    .last_end_serial_io_in(l_in), .last_end_serial_io_out(l_out),
    .last_end_serial_io_oe_n(l_oe), .row_drive);
  lrs_ctrl_model u_lrs_ctrl_model (.hclk, .hresetn, .go, .d_first, .d_last, .d_mid,
    .scan_shift_clock(scan), .first_pin(m_first), .last_pin(m_last), .mid_pin(m_mid), .busy);
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single AHB transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, {24'h0, a}, 32'h0, v);
    check(v, exp);
  endtask
  task automatic set_ctrl(input logic [2:0] c);
    logic [31:0] v;
    bus(1'b1, {24'h0, ADDR_CTRL}, {29'h0, c}, v);
    ctrl = c;
  endtask
  // Expected level code of one row
  function automatic logic [1:0] code(input logic b);
    if (!ctrl[CTRL_BLANK_BIT]) return LVL_TOP_SELECTED;
    if (b) return alt ? LVL_TOP_SELECTED : LVL_BOTTOM_SELECTED;
    return alt ? LVL_LOWER_UNSELECTED : LVL_UPPER_UNSELECTED;
  endfunction
  // One scan pulse, then the same step on the reference chain
  task automatic shift(input logic f, input logic l, input logic m);
    @(posedge hclk);
    d_first <= f;
    d_last <= l;
    d_mid <= m;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    // The model only shows busy from the edge after it took go
    @(posedge hclk);
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge hclk);
    if (ctrl[CTRL_DIR_BIT]) ref_q = {l, ref_q[STAGES-1:1]};
    else ref_q = {ref_q[STAGES-2:0], f};
    if (ctrl[CTRL_SPLIT_BIT]) ref_q[ctrl[CTRL_DIR_BIT] ? HALF-1 : HALF] = m;
  endtask
  task automatic check_all();
    rd_chk(ADDR_CHAIN0, ref_q[31:0]);
    rd_chk(ADDR_CHAIN1, ref_q[63:32]);
    rd_chk(ADDR_CHAIN2, {16'h0, ref_q[79:64]});
    check({30'h0, f_oe, l_oe}, {30'h0, ~ctrl[CTRL_DIR_BIT], ctrl[CTRL_DIR_BIT]});
    if (ctrl[CTRL_DIR_BIT]) check({31'h0, f_out}, {31'h0, ref_q[0]});
    else check({31'h0, l_out}, {31'h0, ref_q[STAGES-1]});
    for (int i = 0; i < STAGES; i++) check({30'h0, row_drive[2*i+:2]}, {30'h0, code(ref_q[i])});
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // Test sequence
  // ----
  initial
  begin
    logic [31:0] v;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    rd_chk(ADDR_CTRL, {29'h0, CTRL_RESET});
    rd_chk(ADDR_SHIFTS, SHIFTS_RESET);
    bus(1'b1, 32'h20, 32'hffff_ffff, v);
    rd_chk(8'h20, 32'h0);
    rd_chk(ADDR_CTRL, {29'h0, CTRL_RESET});
    $display("test reset done");
    // Every split and direction pair; mid held high even where it must be ignored
    for (int m = 0; m < 4; m++)
    begin
      set_ctrl({1'b1, m[1], m[0]});
      for (int k = 0; k < (m == 0 ? STAGES : 6); k++)
      begin
        alt <= k[1];
        shift(k[0], ~k[0], 1'b1);
        check_all();
      end
      $display("test mode %0d done", m);
    end
    rd_chk(ADDR_SHIFTS, 32'h62);
    set_ctrl(3'h1);
    check_all();
    $display("test blank done");
    end_sim();
  end
  // Watchdog well beyond the roughly 3000 cycles the tests need
  initial
  begin
    #400000;
    miscompares++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule // lrs_tb_top
